/* verilog/irc_top.v */
`timescale 1ns/1ns
`include "irc_defines.vh"
module irc_top #(
    parameter [23:0] WDOG_CYCLES = `IRC_WDOG_CYCLES
) (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Processor core
    input  wire        i_mask_i,
    input  wire        special_mode_i,
    input  wire        int_ack_i,
    output reg         int_pend_o,
    output reg  [15:0] vec_hi_addr_o,
    output reg  [15:0] vec_lo_addr_o,
    output wire        core_reset_o,
    output reg  [15:0] reset_vec_o,
    // Peripheral sources, slot 0 is the pin
    input  wire [15:1] src_req_i,
    input  wire [15:1] src_en_i,
    // Stop mode
    input  wire        stop_exit_i,
    output reg         stop_done_o,
    // Clock monitor reference
    input  wire        cm_ref_tick_i,
    // Board pins
    input  wire        ext_int_n_i,
    input  wire        rst_pin_n_i,
    output wire        rst_pin_o,
    output wire        rst_pin_oe_o
);
    // ----------------------------------------
    // Counts and states
    // ----------------------------------------
    localparam [7:0]  DRV_CYC = (`IRC_RST_DRV_E * `IRC_E_NS +
                                 `IRC_CLK_NS - 1) / `IRC_CLK_NS;
    localparam [7:0]  SMP_CYC = (`IRC_RST_SMP_E * `IRC_E_NS +
                                 `IRC_CLK_NS - 1) / `IRC_CLK_NS;
    localparam [12:0] STOP_CYC = (`IRC_STOP_DLY_E * `IRC_E_NS +
                                  `IRC_CLK_NS - 1) / `IRC_CLK_NS;
    localparam [23:0] WD_LAST = WDOG_CYCLES - 24'd1;
    localparam [7:0]  ICR_RST = `IRC_INTCTL_RST, WCR_RST = `IRC_WDCTL_RST;

    localparam [3:0]  ST_RUN   = 4'b0001;
    localparam [3:0]  ST_DRIVE = 4'b0010;
    localparam [3:0]  ST_WAIT  = 4'b0100;
    localparam [3:0]  ST_HOLD  = 4'b1000;

    localparam [1:0]  C_MAIN = 2'b00;
    localparam [1:0]  C_WDOG = 2'b01;
    localparam [1:0]  C_CMON = 2'b10;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    reg  [3:0]  state;
    reg  [7:0]  rst_cnt;
    reg  [1:0]  cause;
    reg         cause_por;
    reg  [3:0]  rst_stat;

    reg         edge_only;
    reg         pin_connect;
    reg         stop_delay;
    reg         edge_seen;
    reg         dly_seen;
    reg  [7:0]  top_sel;
    reg         wd_en;
    reg         cm_en;

    reg         pin_prev;
    reg         edge_latch;
    reg  [3:0]  win_q;

    reg  [23:0] wd_cnt;
    reg         wd_armed;

    reg  [12:0] stop_cnt;
    reg         stop_busy;

    reg  [7:0]  rd_byte;

    wire        reg_rst;
    wire        wb_req;
    wire [5:0]  wb_idx;
    wire        wb_wr;
    wire [7:0]  wbyte;
    wire        wr_intctl;
    wire        wr_prio;
    wire        wr_wdctl;
    wire        wr_svc;
    wire        pin_req;
    wire [15:0] req_all;
    wire        any_req;
    wire [3:0]  win;
    wire [7:0]  win_code;
    wire        wd_bad;
    wire        wd_timeout;
    wire        wdog_trip;
    wire        cm_fail;

    // ----------------------------------------
    // Reset outputs
    // ----------------------------------------
    assign reg_rst      = rst_i | ~state[0];
    assign core_reset_o = rst_i | ~state[0];
    assign rst_pin_o    = 1'b0;
    assign rst_pin_oe_o = rst_i | state[1];

    // ----------------------------------------
    // Wishbone slave
    // ----------------------------------------
    assign wb_req    = wb_cyc_i & wb_stb_i;
    assign wb_idx    = wb_adr_i[7:2];
    assign wb_wr     = wb_req & wb_ack_o & wb_we_i & wb_sel_i[0];
    assign wbyte     = wb_dat_i[7:0];
    assign wr_intctl = wb_wr & (wb_idx == `IRC_IDX_INTCTL);
    assign wr_prio   = wb_wr & (wb_idx == `IRC_IDX_PRIO);
    assign wr_wdctl  = wb_wr & (wb_idx == `IRC_IDX_WDCTL);
    assign wr_svc    = wb_wr & (wb_idx == `IRC_IDX_WDSVC);

    always @* begin
        if (wb_idx == `IRC_IDX_INTCTL) begin
            rd_byte = {edge_only, pin_connect, stop_delay, 5'h00};
        end else if (wb_idx == `IRC_IDX_PRIO) begin
            rd_byte = top_sel;
        end else if (wb_idx == `IRC_IDX_WDCTL) begin
            rd_byte = {wd_en, cm_en, 6'h00};
        end else if (wb_idx == `IRC_IDX_STAT) begin
            rd_byte = {4'h0, rst_stat};
        end else begin
            rd_byte = 8'h00;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req & ~wb_ack_o;
            if (wb_req & ~wb_ack_o) begin
                wb_dat_o <= {24'h000000, rd_byte};
            end
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (reg_rst) begin
            edge_only   <= ICR_RST[`IRC_EDGE_BIT];
            pin_connect <= ICR_RST[`IRC_CONN_BIT];
            stop_delay  <= ICR_RST[`IRC_DLY_BIT];
            edge_seen   <= 1'b0;
            dly_seen    <= 1'b0;
            top_sel     <= `IRC_PRIO_RST;
            wd_en       <= WCR_RST[`IRC_WDEN_BIT];
            cm_en       <= WCR_RST[`IRC_CMEN_BIT];
        end else begin
            if (wr_intctl) begin
                pin_connect <= wbyte[`IRC_CONN_BIT];
                edge_seen   <= 1'b1;
                if (edge_seen ? special_mode_i : ~special_mode_i) begin
                    edge_only <= wbyte[`IRC_EDGE_BIT];
                end
                dly_seen <= 1'b1;
                if (special_mode_i | ~dly_seen) begin
                    stop_delay <= wbyte[`IRC_DLY_BIT];
                end
            end
            if (wr_prio & i_mask_i) begin
                top_sel <= wbyte;
            end
            if (wr_wdctl) begin
                wd_en <= wbyte[`IRC_WDEN_BIT];
                cm_en <= wbyte[`IRC_CMEN_BIT];
            end
        end
    end

    // ----------------------------------------
    // External maskable pin
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (reg_rst) begin
            pin_prev   <= 1'b1;
            edge_latch <= 1'b0;
        end else begin
            pin_prev <= ext_int_n_i;
            if (edge_only & pin_connect & pin_prev & ~ext_int_n_i) begin
                edge_latch <= 1'b1;
            end else if (int_ack_i & int_pend_o & (win_q == 4'h0)) begin
                edge_latch <= 1'b0;
            end
        end
    end

    assign pin_req = pin_connect &
                     (edge_only ? edge_latch : ~ext_int_n_i);

    // ----------------------------------------
    // Maskable arbitration
    // ----------------------------------------
    assign req_all = {src_req_i & src_en_i, pin_req} &
                     {16{~i_mask_i}};

    irc_prio u_prio (
        .req_i     (req_all),
        .top_sel_i (top_sel),
        .any_o     (any_req),
        .win_o     (win)
    );

    assign win_code = `IRC_CODE_TOP - {3'b000, win, 1'b0};

    always @(posedge clk_i) begin
        if (reg_rst) begin
            int_pend_o    <= 1'b0;
            win_q         <= 4'h0;
            vec_hi_addr_o <= {`IRC_VEC_PAGE, `IRC_CODE_TOP};
            vec_lo_addr_o <= {`IRC_VEC_PAGE, `IRC_CODE_TOP | 8'h01};
        end else begin
            int_pend_o    <= any_req;
            win_q         <= win;
            vec_hi_addr_o <= {`IRC_VEC_PAGE, win_code};
            vec_lo_addr_o <= {`IRC_VEC_PAGE, win_code | 8'h01};
        end
    end

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    assign wd_bad = wr_svc & wd_en & (wbyte != `IRC_SVC_ARM) &
                    (wbyte != `IRC_SVC_FIRE);
    assign wd_timeout = wd_en & (wd_cnt == WD_LAST);
    assign wdog_trip  = wd_bad | wd_timeout;

    always @(posedge clk_i) begin
        if (reg_rst | ~wd_en) begin
            wd_cnt   <= 24'h000000;
            wd_armed <= 1'b0;
        end else if (wr_svc & (wbyte == `IRC_SVC_ARM)) begin
            wd_armed <= 1'b1;
            wd_cnt   <= wd_cnt + 24'h000001;
        end else if (wr_svc & (wbyte == `IRC_SVC_FIRE) & wd_armed) begin
            wd_armed <= 1'b0;
            wd_cnt   <= 24'h000000;
        end else begin
            wd_cnt <= wd_cnt + 24'h000001;
        end
    end

    // ----------------------------------------
    // Clock monitor
    // ----------------------------------------
    irc_clkmon u_clkmon (
        .clk_i  (clk_i),
        .rst_i  (reg_rst),
        .en_i   (cm_en),
        .tick_i (cm_ref_tick_i),
        .fail_o (cm_fail)
    );

    // ----------------------------------------
    // Reset sequencer
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            state       <= ST_DRIVE;
            rst_cnt     <= 8'h00;
            cause       <= C_MAIN;
            cause_por   <= 1'b1;
            rst_stat    <= 4'h0;
            reset_vec_o <= `IRC_VEC_MAIN;
        end else begin
            case (state)
            ST_RUN: begin
                rst_cnt <= 8'h00;
                if (cm_fail) begin
                    state     <= ST_DRIVE;
                    cause     <= C_CMON;
                    cause_por <= 1'b0;
                end else if (wdog_trip) begin
                    state     <= ST_DRIVE;
                    cause     <= C_WDOG;
                    cause_por <= 1'b0;
                end else if (~rst_pin_n_i) begin
                    state     <= ST_DRIVE;
                    cause     <= C_MAIN;
                    cause_por <= 1'b0;
                end
            end
            ST_DRIVE: begin
                if (rst_cnt == DRV_CYC - 8'd1) begin
                    state   <= ST_WAIT;
                    rst_cnt <= 8'h00;
                end else begin
                    rst_cnt <= rst_cnt + 8'h01;
                end
            end
            ST_WAIT: begin
                if (rst_cnt == SMP_CYC - 8'd1) begin
                    rst_cnt <= 8'h00;
                    rst_stat <= 4'h0;
                    if (~rst_pin_n_i) begin
                        state <= ST_HOLD;
                        reset_vec_o <= `IRC_VEC_MAIN;
                        rst_stat[`IRC_ST_EXT] <= 1'b1;
                    end else begin
                        state <= ST_RUN;
                        if (cause == C_CMON) begin
                            reset_vec_o <= `IRC_VEC_CMON;
                            rst_stat[`IRC_ST_CMON] <= 1'b1;
                        end else if (cause == C_WDOG) begin
                            reset_vec_o <= `IRC_VEC_WDOG;
                            rst_stat[`IRC_ST_WDOG] <= 1'b1;
                        end else begin
                            reset_vec_o <= `IRC_VEC_MAIN;
                            rst_stat[`IRC_ST_POR] <= cause_por;
                            rst_stat[`IRC_ST_EXT] <= ~cause_por;
                        end
                    end
                end else begin
                    rst_cnt <= rst_cnt + 8'h01;
                end
            end
            ST_HOLD: begin
                if (rst_pin_n_i) begin
                    state <= ST_RUN;
                end
            end
            default: begin
                state   <= ST_DRIVE;
                rst_cnt <= 8'h00;
            end
            endcase
        end
    end

    // ----------------------------------------
    // Stop exit delay
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (reg_rst) begin
            stop_cnt    <= 13'h0000;
            stop_busy   <= 1'b0;
            stop_done_o <= 1'b0;
        end else if (stop_busy) begin
            if (stop_cnt == STOP_CYC - 13'd1) begin
                stop_busy   <= 1'b0;
                stop_done_o <= 1'b1;
            end else begin
                stop_cnt    <= stop_cnt + 13'h0001;
                stop_done_o <= 1'b0;
            end
        end else if (stop_exit_i & stop_delay) begin
            stop_busy   <= 1'b1;
            stop_cnt    <= 13'h0000;
            stop_done_o <= 1'b0;
        end else begin
            stop_done_o <= stop_exit_i;
        end
    end
endmodule // irc_top

/* pkg/irc_defines.vh */
`ifndef IRC_DEFINES_VH
`define IRC_DEFINES_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define IRC_CLK_NS      10
`define IRC_E_NS        10
`define IRC_RST_DRV_E   16
`define IRC_RST_SMP_E   8
`define IRC_STOP_DLY_E  4096
`define IRC_CM_MIN_CLKS 8'h04
`define IRC_WDOG_CYCLES 24'h010000

// ----------------------------------------
// Register indices, byte address is 4x
// ----------------------------------------
`define IRC_IDX_INTCTL  6'h1E
`define IRC_IDX_PRIO    6'h1F
`define IRC_IDX_WDCTL   6'h16
`define IRC_IDX_WDSVC   6'h17
`define IRC_IDX_STAT    6'h18

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define IRC_EDGE_BIT    7
`define IRC_CONN_BIT    6
`define IRC_DLY_BIT     5
`define IRC_WDEN_BIT    7
`define IRC_CMEN_BIT    6
`define IRC_ST_EXT      0
`define IRC_ST_WDOG     1
`define IRC_ST_CMON     2
`define IRC_ST_POR      3
`define IRC_INTCTL_RST  8'h60
`define IRC_PRIO_RST    8'hF2
`define IRC_WDCTL_RST   8'h80

// ----------------------------------------
// Codes and vectors
// ----------------------------------------
`define IRC_CODE_TOP    8'hF2
`define IRC_CODE_LOW    8'hD4
`define IRC_SVC_ARM     8'h55
`define IRC_SVC_FIRE    8'hAA
`define IRC_VEC_PAGE    8'hFF
`define IRC_VEC_MAIN    16'hFFFE
`define IRC_VEC_CMON    16'hFFFC
`define IRC_VEC_WDOG    16'hFFFA

`endif

/* verilog/irc_prio.v */
`timescale 1ns/1ns
`include "irc_defines.vh"
module irc_prio (
    // Gated requests and priority code
    input  wire [15:0] req_i,
    input  wire [7:0]  top_sel_i,
    // Winner
    output reg         any_o,
    output reg  [3:0]  win_o
);
    // ----------------------------------------
    // Raised source
    // ----------------------------------------
    wire [7:0]  span   = `IRC_CODE_TOP - top_sel_i;
    wire        top_ok = (top_sel_i <= `IRC_CODE_TOP) &
                         (top_sel_i >= `IRC_CODE_LOW) & ~top_sel_i[0];
    wire [3:0]  top_idx = top_ok ? span[4:1] : 4'h0;
    wire [15:0] is_top;
    integer     i;

    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_top
            localparam [3:0] K = g;
            assign is_top[g] = req_i[g] & (top_idx == K);
        end
    endgenerate

    // ----------------------------------------
    // Fixed order below the raised one
    // ----------------------------------------
    always @* begin
        any_o = |req_i;
        win_o = 4'h0;
        if (|is_top) begin
            win_o = top_idx;
        end else begin
            for (i = 15; i >= 0; i = i - 1) begin
                if (req_i[i]) begin
                    win_o = i[3:0];
                end
            end
        end
    end
endmodule // irc_prio

/* verilog/irc_clkmon.v */
`timescale 1ns/1ns
`include "irc_defines.vh"
module irc_clkmon (
    // Clock and reset
    input  wire clk_i,
    input  wire rst_i,
    // Control and reference
    input  wire en_i,
    input  wire tick_i,
    // Result
    output reg  fail_o
);
    // ----------------------------------------
    // Clocks counted per reference tick
    // ----------------------------------------
    reg [7:0] cnt;

    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt    <= 8'hFF;
            fail_o <= 1'b0;
        end else if (!en_i) begin
            cnt    <= 8'hFF;
            fail_o <= 1'b0;
        end else if (tick_i) begin
            fail_o <= (cnt < `IRC_CM_MIN_CLKS);
            cnt    <= 8'h00;
        end else begin
            fail_o <= 1'b0;
            if (cnt != 8'hFF) begin
                cnt <= cnt + 8'h01;
            end
        end
    end
endmodule // irc_clkmon

/* test/irc_core_model.sv */
`timescale 1ns/1ns
module irc_core_model (
    // Clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // Bench control
    input  wire       auto_ack_i,
    input  wire [3:0] lag_i,
    // Interrupt side
    input  wire       int_pend_i,
    output reg        int_ack_o
);
    reg [3:0] wait_cnt;
    // Takes the vector after a chosen lag
    always @(posedge clk_i) begin
        if (rst_i || int_ack_o || !int_pend_i || !auto_ack_i) begin
            wait_cnt  <= 4'h0;
            int_ack_o <= 1'h0;
        end else if (wait_cnt == lag_i) begin
            int_ack_o <= 1'h1;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule // irc_core_model

/* test/irc_top_monitor.sv */
`timescale 1ns/1ns
module irc_top_monitor (
    // Clock, reset, bus
    input wire        clk_i,
    input wire        rst_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire        wb_ack_o,
    // Core side
    input wire        i_mask_i,
    input wire        int_pend_o,
    input wire [15:0] vec_hi_addr_o,
    input wire [15:0] vec_lo_addr_o,
    input wire        core_reset_o,
    input wire [15:1] src_req_i,
    input wire [15:1] src_en_i,
    // Reset pin
    input wire        rst_pin_n_i,
    input wire        rst_pin_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    reg [7:0] drv_len;
    always @(posedge clk_i) begin
        drv_len <= (rst_i || !rst_pin_oe_o) ? 8'h00 : drv_len + 8'h01;
    end
    property p_ack_resp;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("bus ack wrong");
    property p_vec_pair;
        int_pend_o |-> vec_hi_addr_o[15:8] == 8'hFF && !vec_hi_addr_o[0]
            && vec_lo_addr_o == (vec_hi_addr_o | 16'h0001);
    endproperty
    a_vec_pair: assert property (p_vec_pair) else $error("vector pair");
    property p_masked;
        i_mask_i |=> !int_pend_o;
    endproperty
    a_masked: assert property (p_masked) else $error("masked pend");
    property p_pa_pend;
        src_req_i[12] && src_en_i[12] && !i_mask_i && !core_reset_o
            |=> int_pend_o;
    endproperty
    a_pa_pend: assert property (p_pa_pend) else $error("edge src");
    property p_ser_pend;
        src_req_i[13] && src_en_i[13] && !i_mask_i && !core_reset_o
            |=> int_pend_o;
    endproperty
    a_ser_pend: assert property (p_ser_pend) else $error("serial");
    property p_drive16;
        $fell(rst_pin_oe_o) |-> drv_len == 8'h10;
    endproperty
    a_drive16: assert property (p_drive16) else $error("drive len");
    property p_wait8;
        $fell(rst_pin_oe_o) |-> core_reset_o [*8];
    endproperty
    a_wait8: assert property (p_wait8) else $error("sample wait");
    property p_hold_ext;
        !rst_pin_n_i && !rst_pin_oe_o |=> core_reset_o;
    endproperty
    a_hold_ext: assert property (p_hold_ext) else $error("ext hold");
    property p_drive_core;
        rst_pin_oe_o |-> core_reset_o;
    endproperty
    a_drive_core: assert property (p_drive_core) else $error("entry");
    property p_wd_bad;
        wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == 6'h17
            && wb_dat_i[7:0] != 8'h55 && wb_dat_i[7:0] != 8'hAA
            && !core_reset_o |-> ##[1:3] rst_pin_oe_o;
    endproperty
    a_wd_bad: assert property (p_wd_bad) else $error("bad service");
endmodule // irc_top_monitor
bind irc_top irc_top_monitor u_mon (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .i_mask_i(i_mask_i), .int_pend_o(int_pend_o),
    .vec_hi_addr_o(vec_hi_addr_o), .vec_lo_addr_o(vec_lo_addr_o),
    .core_reset_o(core_reset_o), .src_req_i(src_req_i),
    .src_en_i(src_en_i), .rst_pin_n_i(rst_pin_n_i),
    .rst_pin_oe_o(rst_pin_oe_o)
);

/* test/test_interrupt_reset_control.sv */
`timescale 1ns/1ns
`include "irc_defines.vh"
module test_interrupt_reset_control;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i, rdat;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        i_mask_i, special_mode_i, int_ack_i, int_pend_o;
    logic [15:0] vec_hi_addr_o, vec_lo_addr_o, reset_vec_o;
    logic        core_reset_o, stop_exit_i, stop_done_o, cm_ref_tick_i;
    logic [15:1] src_req_i, src_en_i;
    logic        ext_int_n_i, rst_pin_o, rst_pin_oe_o, board_rst_n, auto_ack;
    wire         rst_pin_n_i;
    integer      failures, checks_done, n, i;
    assign rst_pin_n_i = board_rst_n & ~rst_pin_oe_o;
    irc_top #(.WDOG_CYCLES(24'h000040)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .i_mask_i(i_mask_i),
        .special_mode_i(special_mode_i), .int_ack_i(int_ack_i),
        .int_pend_o(int_pend_o), .vec_hi_addr_o(vec_hi_addr_o),
        .vec_lo_addr_o(vec_lo_addr_o), .core_reset_o(core_reset_o),
        .reset_vec_o(reset_vec_o), .src_req_i(src_req_i),
        .src_en_i(src_en_i), .stop_exit_i(stop_exit_i),
        .stop_done_o(stop_done_o), .cm_ref_tick_i(cm_ref_tick_i),
        .ext_int_n_i(ext_int_n_i), .rst_pin_n_i(rst_pin_n_i),
        .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o)
    );
    irc_core_model u_core (
        .clk_i(clk_i), .rst_i(rst_i), .auto_ack_i(auto_ack),
        .lag_i(4'h3), .int_pend_i(int_pend_o), .int_ack_o(int_ack_i)
    );
    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        #200000;
        failures = failures + 1;
        tally_and_finish;
    end
    // ------------------------------------------
    // Tasks
    // ------------------------------------------
    task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wb(input logic we, input logic [5:0] idx, input logic [7:0] d);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'h0};
        wb_dat_i <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n = n + 1;
        end while (wb_ack_o !== 1'h1 && n < 20);
        chk("ack", 16'h0001, {15'h0000, wb_ack_o});
        rdat = wb_dat_o[7:0];
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        @(posedge clk_i);
    endtask
    task wr(input logic [5:0] idx, input logic [7:0] d);
        wb(1'h1, idx, d);
    endtask
    task rd(input logic [5:0] idx, input logic [7:0] exp, input string nm);
        wb(1'h0, idx, 8'h00);
        chk(nm, {8'h00, exp}, {8'h00, rdat});
    endtask
    task tick(input integer k);
        repeat (k) @(posedge clk_i);
    endtask
    task wait_core(input logic v, input integer lim);
        n = 0;
        while (core_reset_o !== v && n < lim) begin
            @(posedge clk_i);
            n = n + 1;
        end
        chk("core_reset", {15'h0000, v}, {15'h0000, core_reset_o});
    endtask
    task pend_is(input logic v);
        chk("int_pend", {15'h0000, v}, {15'h0000, int_pend_o});
    endtask
    task vec_is(input logic [7:0] code);
        chk("vec_hi", {8'hFF, code}, vec_hi_addr_o);
        chk("vec_lo", {8'hFF, code | 8'h01}, vec_lo_addr_o);
    endtask
    task set_prio(input logic [7:0] d);
        i_mask_i <= 1'h1;
        wr(`IRC_IDX_PRIO, d);
        rd(`IRC_IDX_PRIO, d, "prio");
        i_mask_i <= 1'h0;
        tick(2);
    endtask
    task stop_len(input integer exp);
        stop_exit_i <= 1'h1;
        @(posedge clk_i);
        stop_exit_i <= 1'h0;
        n = 0;
        do begin
            @(posedge clk_i);
            n = n + 1;
        end while (stop_done_o !== 1'h1 && n < 5000);
        chk("stop_len", exp[15:0], n[15:0]);
    endtask
    task tally_and_finish;
        if (failures == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ------------------------------------------
    // Tests
    // ------------------------------------------
    initial begin
        failures = 0;
        checks_done = 0;
        rst_i = 1'h1;
        {wb_cyc_i, wb_stb_i, wb_we_i, stop_exit_i, cm_ref_tick_i} = 5'h00;
        {special_mode_i, auto_ack, src_req_i, src_en_i} = 32'h00000000;
        {i_mask_i, ext_int_n_i, board_rst_n} = 3'h7;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h1;
        wb_dat_i = 32'h00000000;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'h0;
        wait_core(1'h0, 300);
        chk("reset_vec", `IRC_VEC_MAIN, reset_vec_o);
        chk("rst_pin", 16'h0000, {15'h0000, rst_pin_o});
        rd(`IRC_IDX_STAT, 8'h08, "status");
        rd(`IRC_IDX_INTCTL, 8'h60, "int_ctl");
        rd(`IRC_IDX_PRIO, 8'hF2, "prio");
        wr(`IRC_IDX_WDCTL, 8'h00);
        rd(6'h01, 8'h00, "unmapped");
        i_mask_i <= 1'h0;
        wr(`IRC_IDX_PRIO, 8'hF0);
        rd(`IRC_IDX_PRIO, 8'hF2, "prio");
        src_en_i <= 15'h7FFF;
        src_req_i <= 15'h0401; // Slots 1 and 11
        set_prio(8'hF0);
        vec_is(8'hF0);
        set_prio(8'hDC);
        vec_is(8'hDC);
        ext_int_n_i <= 1'h0;
        for (i = 0; i < 3; i = i + 1) begin
            set_prio(i == 0 ? 8'hF4 : i == 1 ? 8'hF1 : 8'hC0);
            vec_is(8'hF2);
        end
        ext_int_n_i <= 1'h1;
        for (i = 11; i < 14; i = i + 1) begin
            src_req_i <= 15'h0001 << (i - 1);
            src_en_i <= 15'h7FFF ^ (15'h0001 << (i - 1));
            tick(2);
            pend_is(1'h0);
            src_en_i <= 15'h7FFF;
            tick(2);
            pend_is(1'h1);
            vec_is(8'(8'hF2 - 8'h02 * i));
            i_mask_i <= 1'h1;
            tick(2);
            pend_is(1'h0);
            i_mask_i <= 1'h0;
        end
        src_req_i <= 15'h0000;
        wr(`IRC_IDX_INTCTL, 8'hA0);
        rd(`IRC_IDX_INTCTL, 8'hA0, "int_ctl");
        ext_int_n_i <= 1'h0;
        tick(2);
        pend_is(1'h0);
        wr(`IRC_IDX_INTCTL, 8'h40);
        rd(`IRC_IDX_INTCTL, 8'hE0, "int_ctl");
        auto_ack <= 1'h1;
        ext_int_n_i <= 1'h1;
        tick(8);
        pend_is(1'h0);
        ext_int_n_i <= 1'h0;
        tick(3);
        pend_is(1'h1);
        tick(8);
        pend_is(1'h0);
        ext_int_n_i <= 1'h1;
        auto_ack <= 1'h0;
        stop_len(4097);
        wr(`IRC_IDX_WDCTL, 8'h40);
        for (i = 0; i < 6; i = i + 1) begin
            cm_ref_tick_i <= 1'h1;
            @(posedge clk_i);
            cm_ref_tick_i <= 1'h0;
            @(posedge clk_i);
        end
        wait_core(1'h1, 20);
        wait_core(1'h0, 300);
        chk("reset_vec", `IRC_VEC_CMON, reset_vec_o);
        rd(`IRC_IDX_STAT, 8'h04, "status");
        for (i = 0; i < 4; i = i + 1) begin
            wr(`IRC_IDX_WDSVC, `IRC_SVC_ARM);
            tick(20);
            wr(`IRC_IDX_WDSVC, `IRC_SVC_FIRE);
        end
        chk("core_reset", 16'h0000, {15'h0000, core_reset_o});
        wait_core(1'h1, 100);
        wait_core(1'h0, 300);
        chk("reset_vec", `IRC_VEC_WDOG, reset_vec_o);
        rd(`IRC_IDX_STAT, 8'h02, "status");
        wr(`IRC_IDX_WDSVC, 8'h12);
        wait_core(1'h1, 5);
        wait_core(1'h0, 300);
        chk("reset_vec", `IRC_VEC_WDOG, reset_vec_o);
        board_rst_n <= 1'h0;
        tick(40);
        board_rst_n <= 1'h1;
        wait_core(1'h0, 300);
        chk("reset_vec", `IRC_VEC_MAIN, reset_vec_o);
        rd(`IRC_IDX_STAT, 8'h01, "status");
        rst_i <= 1'h1;
        special_mode_i <= 1'h1;
        tick(6);
        rst_i <= 1'h0;
        wait_core(1'h0, 300);
        wr(`IRC_IDX_WDCTL, 8'h00);
        wr(`IRC_IDX_INTCTL, 8'hC0);
        rd(`IRC_IDX_INTCTL, 8'h40, "int_ctl");
        stop_len(1);
        wr(`IRC_IDX_INTCTL, 8'hE0);
        rd(`IRC_IDX_INTCTL, 8'hE0, "int_ctl");
        tally_and_finish;
    end
endmodule // test_interrupt_reset_control
